// *** include/cfp_pkg.sv ***
// Package of constants for the channel fault protection block
package cfp_pkg;
  localparam int NUM_CH = 2;
  localparam int SP_W = 11;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  // Overcurrent filter, cycles of mclk (window 20..40)
  localparam int OC_FILT_CYC = 30;
  localparam int FILT_W = 6;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] SETPT0_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] SETPT1_OFF = 12'h004;
  localparam logic [ADDR_W-1:0] DIAG_OFF = 12'h008;
  localparam logic [ADDR_W-1:0] MASK_OFF = 12'h00c;
  localparam logic [ADDR_W-1:0] STAT_OFF = 12'h010;
  // Diagnosis field positions
  localparam int DIAG_OVC_POS = 0;
  localparam int DIAG_OT_POS = 2;
  localparam int DIAG_OV_POS = 4;
  localparam int DIAG_W = 5;
  // Mask field positions
  localparam int MASK_FM_POS = 0;
  localparam int MASK_OV_POS = 2;
  localparam int MASK_W = 3;
  localparam logic [MASK_W-1:0] MASK_RST = 3'h7;
  localparam logic [SP_W-1:0] SP_RST = 11'h000;
endpackage

// *** rtl/cfp_protect.sv ***
// Two-channel fault protection with APB register access
// Operation
// RULE1: Detected overload turns channel off, zeroes setpoint, sets overcurrent flag.
// RULE2: Diagnosis register read clears the latched overcurrent flag.
// RULE3: After overcurrent, only a nonzero setpoint write re-enables the channel.
// RULE4: Overload must persist a 20 to 40 cycle filter before detection.
// RULE5: Each channel has its own overtemperature input acting only on it.
// RULE6: Overtemperature turns the channel off and forces its setpoint to zero.
// RULE7: After overtemperature, stay off until cooled and a nonzero setpoint written.
// RULE8: Overtemperature flag latched; cleared by read while overheat is absent.
// RULE9: Battery overvoltage sets the overvoltage flag.
// RULE10: Overvoltage flag held until a read while overvoltage is absent.
// RULE11: While overvoltage persists, all channels off and all setpoints zero.
// RULE12: Fault output pulled low on any unmasked fault.
// RULE13: Filter counter restarts whenever overload drops before completing.
//
// Chosen here: the register offsets and the APB slave port.
module cfp_protect (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          clkEn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cfp_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [cfp_pkg::DATA_W-1:0]    pwdata,
  output logic      [cfp_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Comparator inputs
  input  wire logic [cfp_pkg::NUM_CH-1:0]    overloadIn,
  input  wire logic [cfp_pkg::NUM_CH-1:0]    overTempIn,
  input  wire logic [cfp_pkg::NUM_CH-1:0]    coolIn,
  input  wire logic                          batOverVoltIn,
  // Channel outputs
  output logic      [cfp_pkg::NUM_CH-1:0]    chanEn,
  output logic      [cfp_pkg::SP_W-1:0]      setpoint0,
  output logic      [cfp_pkg::SP_W-1:0]      setpoint1,
  // Fault pin and interrupt
  output logic                               faultOut,
  output logic                               faultOutEn_n,
  output logic                               irq
);
  typedef struct packed {
    logic [cfp_pkg::NUM_CH-1:0][cfp_pkg::SP_W-1:0]   sp;
    logic [cfp_pkg::NUM_CH-1:0]                      en;
    logic [cfp_pkg::NUM_CH-1:0]                      hot;
    logic [cfp_pkg::NUM_CH-1:0][cfp_pkg::FILT_W-1:0] filt;
    logic [cfp_pkg::NUM_CH-1:0]                      ovc;
    logic [cfp_pkg::NUM_CH-1:0]                      ot;
    logic                                            ov;
    logic [cfp_pkg::MASK_W-1:0]                      mask;
    logic [cfp_pkg::DATA_W-1:0]                      rdata;
  } cfp_state_t;

  cfp_state_t stateReg;
  cfp_state_t stateNext;

  logic                       apbAcc;
  logic                       apbWr;
  logic                       apbRd;
  logic                       mapped;
  logic [cfp_pkg::DIAG_W-1:0] diagVal;
  logic [cfp_pkg::NUM_CH-1:0] ocDet;
  logic [cfp_pkg::NUM_CH-1:0] spWr;
  logic                       diagRd;

  assign apbAcc = psel && penable;
  assign apbWr = apbAcc && pwrite;
  assign apbRd = apbAcc && !pwrite;
  assign mapped = (paddr == cfp_pkg::SETPT0_OFF) || (paddr == cfp_pkg::SETPT1_OFF) ||
                  (paddr == cfp_pkg::DIAG_OFF) || (paddr == cfp_pkg::MASK_OFF) ||
                  (paddr == cfp_pkg::STAT_OFF);
  assign diagRd = apbRd && (paddr == cfp_pkg::DIAG_OFF) && clkEn;
  assign diagVal = {stateReg.ov, stateReg.ot, stateReg.ovc};

  always_comb begin
    stateNext = stateReg;
    ocDet = '0;
    spWr = '0;
    spWr[0] = apbWr && clkEn && (paddr == cfp_pkg::SETPT0_OFF);
    spWr[1] = apbWr && clkEn && (paddr == cfp_pkg::SETPT1_OFF);
    // Read data captured at the setup edge, valid through the access phase
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        cfp_pkg::SETPT0_OFF: stateNext.rdata = 32'(stateReg.sp[0]);
        cfp_pkg::SETPT1_OFF: stateNext.rdata = 32'(stateReg.sp[1]);
        cfp_pkg::DIAG_OFF:   stateNext.rdata = 32'(diagVal);
        cfp_pkg::MASK_OFF:   stateNext.rdata = 32'(stateReg.mask);
        cfp_pkg::STAT_OFF:   stateNext.rdata = 32'({stateReg.hot, stateReg.en});
        default:             stateNext.rdata = 32'h0000_0000;
      endcase
    end
    if (apbWr && (paddr == cfp_pkg::MASK_OFF)) begin
      stateNext.mask = pwdata[cfp_pkg::MASK_W-1:0];
    end
    // Read clears only flags it reported; later faults stay set
    if (diagRd) begin
      stateNext.ovc = stateReg.ovc
                      & ~stateReg.rdata[cfp_pkg::DIAG_OVC_POS +: cfp_pkg::NUM_CH]; // RULE2
      stateNext.ot = stateReg.ot & (overTempIn
                     | ~stateReg.rdata[cfp_pkg::DIAG_OT_POS +: cfp_pkg::NUM_CH]); // RULE8
      stateNext.ov = stateReg.ov
                     & (batOverVoltIn || !stateReg.rdata[cfp_pkg::DIAG_OV_POS]); // RULE10
    end
    for (int c = 0; c < cfp_pkg::NUM_CH; c++) begin
      // Continuous overload filter while channel on
      if (overloadIn[c] && stateReg.en[c]) begin
        if (stateReg.filt[c] >= cfp_pkg::FILT_W'(cfp_pkg::OC_FILT_CYC - 1)) begin
          ocDet[c] = 1'b1; // RULE4
          stateNext.filt[c] = '0;
        end else begin
          stateNext.filt[c] = stateReg.filt[c] + cfp_pkg::FILT_W'(1);
        end
      end else begin
        stateNext.filt[c] = '0; // RULE13
      end
      if (coolIn[c]) begin
        stateNext.hot[c] = 1'b0; // RULE7
      end
      if (spWr[c]) begin
        stateNext.sp[c] = pwdata[cfp_pkg::SP_W-1:0];
        stateNext.en[c] = (pwdata[cfp_pkg::SP_W-1:0] != '0) && !stateReg.hot[c]
                          && !overTempIn[c]; // RULE3 RULE7
      end
      if (ocDet[c]) begin
        stateNext.en[c] = 1'b0; // RULE1
        stateNext.sp[c] = cfp_pkg::SP_RST;
        stateNext.ovc[c] = 1'b1;
        stateNext.filt[c] = '0;
      end
      if (overTempIn[c]) begin
        stateNext.en[c] = 1'b0; // RULE5 RULE6
        stateNext.sp[c] = cfp_pkg::SP_RST;
        stateNext.hot[c] = 1'b1;
        stateNext.ot[c] = 1'b1; // RULE8
      end
      if (batOverVoltIn) begin
        stateNext.en[c] = 1'b0; // RULE11
        stateNext.sp[c] = cfp_pkg::SP_RST;
        stateNext.filt[c] = '0;
      end
    end
    if (batOverVoltIn) begin
      stateNext.ov = 1'b1; // RULE9
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stateReg <= '{sp: '0, en: '0, hot: '0, filt: '0, ovc: '0, ot: '0, ov: 1'b0,
                    mask: cfp_pkg::MASK_RST, rdata: '0};
    end else if (clkEn) begin
      stateReg <= stateNext;
    end
  end

  logic [cfp_pkg::NUM_CH-1:0] chanFault;
  logic                       anyFault;
  assign chanFault = (stateReg.ovc | stateReg.ot) & stateReg.mask[cfp_pkg::NUM_CH-1:0];
  assign anyFault = (|chanFault) || (stateReg.ov && stateReg.mask[cfp_pkg::MASK_OV_POS]);

  assign prdata = stateReg.rdata;
  assign pready = 1'b1;
  assign pslverr = apbAcc && !mapped;
  assign chanEn = stateReg.en;
  assign setpoint0 = stateReg.sp[0];
  assign setpoint1 = stateReg.sp[1];
  assign faultOut = 1'b0;
  assign faultOutEn_n = !anyFault; // RULE12
  assign irq = anyFault;
endmodule

// *** sim/cfp_mcu_model.sv ***
// Controller model: register master on the bus
module cfp_mcu_model (
  input  logic        mclk,
  input  logic        pready,
  input  logic [31:0] prdata,
  output logic        psel = 1'b0,
  output logic        penable = 1'b0,
  output logic        pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Read data taken at the edge that completes the access
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1'b1;
    do @(posedge mclk); while (!pready);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
endmodule

// *** sim/cfp_protect_monitor.sv ***
// Port checks for the fault protection block
module cfp_protect_monitor (
  // Clock, reset, bus strobes
  input logic        mclk, rst_n, psel, penable, pwrite,
  // Faults and channel outputs
  input logic [1:0]  overloadIn, overTempIn, coolIn, chanEn,
  input logic        batOverVoltIn, faultOutEn_n, irq,
  input logic [10:0] setpoint0
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_off_zero: assert property ($fell(chanEn[0]) |-> setpoint0 == 0)
    else $error("channel off, setpoint kept");
  a_oc_filter: assert property ($rose(overloadIn[0]) && chanEn[0] && !overTempIn[0] &&
    !batOverVoltIn |=> chanEn[0] [*8]) else $error("overload acted early");
  a_ov_off: assert property (batOverVoltIn |=> chanEn == 0 && setpoint0 == 0)
    else $error("channel on in overvoltage");
  a_ot_off: assert property (overTempIn[0] |=> !chanEn[0] && setpoint0 == 0)
    else $error("channel on while hot");
  a_ot_own: assert property (overTempIn[1] && !overTempIn[0] && !overloadIn[0] &&
    !batOverVoltIn && chanEn[0] |=> chanEn[0]) else $error("wrong channel off");
  a_pin_irq: assert property (irq != faultOutEn_n)
    else $error("pin and irq differ");
  a_en_write: assert property ($rose(chanEn[0]) |-> $past(psel && penable && pwrite))
    else $error("enable without write");
  a_en_cool: assert property (overTempIn[0] ##1 !coolIn[0] [*2] |-> !chanEn[0])
    else $error("enabled before cooling");
  c_oc: cover property ($fell(chanEn[0]) && !overTempIn[0]);
  c_ov: cover property (batOverVoltIn);
  c_irq: cover property ($rose(irq));
endmodule
bind cfp_protect cfp_protect_monitor i_cfp_protect_monitor (.mclk, .rst_n, .psel, .penable,
  .pwrite, .overloadIn, .overTempIn, .coolIn, .chanEn, .batOverVoltIn, .faultOutEn_n, .irq,
  .setpoint0);

// *** sim/cfp_protect_tb_top.sv ***
// Self-checking bench for the fault protection block
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module cfp_protect_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [1:0] ol, ot; logic ov; logic [1:0] en; logic [4:0] dg;} cfp_row_t;
  cfp_row_t rows[5] = '{'{2'h1, 2'h0, 1'b0, 2'h2, 5'h01}, '{2'h2, 2'h0, 1'b0, 2'h1, 5'h02},
    '{2'h0, 2'h1, 1'b0, 2'h2, 5'h04}, '{2'h0, 2'h2, 1'b0, 2'h1, 5'h08},
    '{2'h0, 2'h0, 1'b1, 2'h0, 5'h10}};
  logic mclk = 0, rst_n = 0, ov = 0, psel, penable, pwrite, pready, irq, foEn_n;
  logic [1:0] ol = 0, ot = 0, cool = 0, chanEn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [10:0] sp0, sp1;
  int error_cnt = 0, n_tests = 0;
  always #4 mclk = ~mclk;
  cfp_mcu_model i_cfp_mcu_model (.mclk(mclk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  cfp_protect i_cfp_protect (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .overloadIn(ol), .overTempIn(ot), .coolIn(cool),
    .batOverVoltIn(ov), .chanEn(chanEn), .setpoint0(sp0), .setpoint1(sp1), .faultOut(),
    .faultOutEn_n(foEn_n), .irq(irq));
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_cfp_mcu_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    i_cfp_mcu_model.xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(cfp_pkg::MASK_OFF, 32'h7);
    rd(cfp_pkg::STAT_OFF, 32'h0);
    foreach (rows[i]) begin
      wr(cfp_pkg::SETPT0_OFF, 32'h123);
      wr(cfp_pkg::SETPT1_OFF, 32'h55);
      `CHK(chanEn, 2'h3)
      ol <= rows[i].ol;
      ot <= rows[i].ot;
      ov <= rows[i].ov;
      repeat (32) @(posedge mclk);
      `CHK({chanEn, irq}, {rows[i].en, 1'b1})
      `CHK({sp0, sp1}, {rows[i].en[0] ? 11'h123 : 11'h0, rows[i].en[1] ? 11'h55 : 11'h0})
      {ol, ot, ov, cool} <= {2'h0, 2'h0, 1'b0, 2'h3};
      @(posedge mclk) cool <= 2'h0;
      rd(cfp_pkg::DIAG_OFF, {27'h0, rows[i].dg});
      rd(cfp_pkg::DIAG_OFF, 32'h0);
      `CHK({chanEn, irq}, {rows[i].en, 1'b0})
    end
    wr(cfp_pkg::SETPT0_OFF, 32'h123);
    for (int k = 0; k < 2; k++) begin
      ol <= 2'h1;
      repeat (29) @(posedge mclk);
      ol <= 2'h0;
      @(posedge mclk);
    end
    `CHK(chanEn[0], 1'b1)
    ol <= 2'h1;
    repeat (32) @(posedge mclk);
    `CHK(chanEn[0], 1'b0)
    ol <= 2'h0;
    rd(cfp_pkg::DIAG_OFF, 32'h1);
    ot <= 2'h1;
    @(posedge mclk);
    rd(cfp_pkg::DIAG_OFF, 32'h4);
    rd(cfp_pkg::DIAG_OFF, 32'h4);
    ot <= 2'h0;
    wr(cfp_pkg::SETPT0_OFF, 32'h123);
    `CHK(chanEn[0], 1'b0)
    rd(cfp_pkg::DIAG_OFF, 32'h4);
    rd(cfp_pkg::DIAG_OFF, 32'h0);
    cool <= 2'h1;
    @(posedge mclk) cool <= 2'h0;
    wr(cfp_pkg::SETPT0_OFF, 32'h123);
    `CHK(chanEn[0], 1'b1)
    wr(cfp_pkg::MASK_OFF, 32'h0);
    ov <= 1'b1;
    @(posedge mclk);
    rd(cfp_pkg::DIAG_OFF, 32'h10);
    `CHK(irq, 1'b0)
    ov <= 1'b0;
    wr(cfp_pkg::MASK_OFF, 32'h7);
    `CHK({irq, foEn_n}, 2'h2)
    rd(cfp_pkg::DIAG_OFF, 32'h10);
    `CHK(irq, 1'b0)
    wr(cfp_pkg::SETPT0_OFF, 32'h123);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    `CHK({chanEn, irq, sp0}, {2'h0, 1'b0, 11'h000})
    rd(cfp_pkg::MASK_OFF, 32'h7);
    rd(12'h020, 32'h0);
    summarize();
  end
endmodule
